// [core/fsc_consts.svh]
/*
 Constants for the frame sync and channel capture core: register offsets,
 field positions, reset values and times in ns. Assumes fsc_pkg types.
*/
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH
// ==================================================
// register byte offsets
`define FSC_ADDR_CTRL 8'h00
`define FSC_ADDR_PAT 8'h04
`define FSC_ADDR_STAT 8'h08
`define FSC_ADDR_IRA 8'h0C
`define FSC_ADDR_IRB 8'h10
`define FSC_ADDR_VIS 8'h20
// ==================================================
// control fields and reset values
`define FSC_CTRL_TOL_LSB 0
`define FSC_CTRL_RATE14 2
`define FSC_CTRL_FRAMES3 3
`define FSC_CTRL_RST 4'h2
`define FSC_PAT_RST 16'hEB90
`define FSC_TOL_MAX 2'h2
`define FSC_RESP_OKAY 2'h0
`define FSC_RESP_SLVERR 2'h2
// ==================================================
// frame geometry: positions in counts of two bits, then line numbers
`define FSC_LAST28 5'h1B
`define FSC_LAST14 5'h0F
`define FSC_HDR_LAST 5'h03
`define FSC_VIS_FIRST 6
`define FSC_VIS_STEP 3
`define FSC_SYNC_LINE 2'h1
`define FSC_IRA_LINE 2'h2
`define FSC_IRB_LINE 2'h3
// ==================================================
// timing: times in ns, clock period in ns
`define FSC_CLK_NS 25
`define FSC_LOCK_WIN_NS 32000
`define FSC_SCAN_NS 30000000
`define FSC_IDLE_NS 1000000000
`endif

// [core/fsc_pkg.sv]
/*
 Types of the frame sync and channel capture core.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fsc_pkg;
	// sync controller states
	typedef enum logic {FSC_SEARCH = 1'b0, FSC_LOCK = 1'b1} fsc_sync_e;
	// one infrared channel pair, binary values
	typedef struct packed {
		logic [7:0] prev;
		logic [7:0] cur;
	} fsc_ir_s;
	// one visual channel pair, raw and linear codes
	typedef struct packed {
		logic [8:0] lin_prev;
		logic [8:0] lin_cur;
		logic [5:0] prev;
		logic [5:0] cur;
	} fsc_vis_s;
	// software control fields
	typedef struct packed {
		logic frames3;
		logic rate14;
		logic [1:0] tol;
	} fsc_ctrl_s;
endpackage

// [core/fsc_lin_rom.sv]
/*
 Six-bit nonlinear visual code to nine-bit linear code lookup.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module fsc_lin_rom
	import fsc_pkg::*;
(
	// code in
	input wire logic [5:0] code,
	// linear value out
	output logic [8:0] lin
);
	// ==================================================
	// interval table: base of each interval and log2 of its step
	localparam logic [8:0] BASE [8] = '{9'h000, 9'h008, 9'h010, 9'h020,
		9'h030, 9'h050, 9'h090, 9'h110};
	localparam logic [2:0] SHIFT [8] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3,
		3'h4, 3'h5};
	logic [8:0] pos;

	// top bits pick the interval, low bits step linearly inside it
	always_comb
	begin
		pos = 9'({6'h00, code[2:0]} << SHIFT[code[5:3]]);
		lin = BASE[code[5:3]] + pos;
	end
endmodule

// [core/fsc_core.sv]
/*
 Frame sync search/lock and channel capture for a two-stream telemetry
 link, with an AXI4-Lite register slave. Assumes link clock, both data
 streams and the scan identifier come from outside the aclk domain.
*/
`timescale 1ns/1ps
`include "fsc_consts.svh"

module fsc_core
	import fsc_pkg::*;
#(
	parameter int SCAN_CYC = `FSC_SCAN_NS / `FSC_CLK_NS,
	parameter int IDLE_CYC = `FSC_IDLE_NS / `FSC_CLK_NS
)
(
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// link pins
	input wire logic link_clk,
	input wire logic link_x,
	input wire logic link_y,
	input wire logic scan_identifier,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// indicators
	output logic lock_ind,
	output logic search_ind,
	// channel outputs
	output logic [1:0] ir_strobe,
	output fsc_ir_s [1:0] ir_out,
	output logic [7:0] vis_strobe,
	output fsc_vis_s [7:0] vis_out
);
	localparam int LOCK_WIN_CYC = `FSC_LOCK_WIN_NS / `FSC_CLK_NS;

	// ==================================================
	// link input synchronisers and edge find
	logic [3:0] pin_s1, pin_s2;
	logic lclk_d, adv, tick;
	logic scan_d, scan_pulse;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			lclk_d <= 1'b0;
			scan_d <= 1'b0;
			adv <= 1'b0;
			tick <= 1'b0;
			scan_pulse <= 1'b0;
		end
		else if (ce)
		begin
			pin_s1 <= {scan_identifier, link_clk, link_x, link_y};
			pin_s2 <= pin_s1;
			lclk_d <= pin_s2[2];
			scan_d <= pin_s2[3];
			adv <= pin_s2[2] & ~lclk_d; // rising link edge brings two bits
			tick <= adv; // shift and counters settled
			scan_pulse <= pin_s2[3] & ~scan_d;
		end
	end

	// ==================================================
	// control registers written by software
	fsc_ctrl_s ctrl;
	logic [15:0] pattern;
	logic [1:0] tol;
	assign tol = (ctrl.tol > `FSC_TOL_MAX) ? `FSC_TOL_MAX : ctrl.tol;

	// ==================================================
	// shift register and counters
	logic [64:0] sr;
	logic [4:0] bit_cnt;
	logic [1:0] line_cnt;
	logic realign;
	logic [4:0] bit_last;
	assign bit_last = ctrl.rate14 ? `FSC_LAST14 : `FSC_LAST28;

	// two bits per link edge, x first
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sr <= '0;
		else if (ce && adv)
			sr <= {sr[62:0], pin_s2[1], pin_s2[0]};
	end

	// bit and line counters; a sync hit puts them at the sync position
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bit_cnt <= 5'h00;
			line_cnt <= 2'h0;
		end
		else if (ce)
		begin
			if (tick && realign)
			begin
				bit_cnt <= `FSC_HDR_LAST;
				line_cnt <= `FSC_SYNC_LINE;
			end
			else if (adv)
			begin
				bit_cnt <= (bit_cnt >= bit_last) ? 5'h00 : bit_cnt + 5'h01;
				if (bit_cnt >= bit_last)
					line_cnt <= line_cnt + 2'h1;
			end
		end
	end

	// ==================================================
	// sync comparison, on time and one bit early
	function automatic logic [4:0] fsc_errs(input logic [15:0] a, input logic [15:0] b);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 16; i++)
			n = n + {4'h0, a[i] ^ b[i]};
		return n;
	endfunction

	logic [15:0] word0, word1;
	logic m0, m1;
	always_comb
	begin
		word0 = ctrl.rate14 ? {sr[39:32], sr[7:0]} : {sr[63:56], sr[7:0]};
		word1 = ctrl.rate14 ? {sr[40:33], sr[8:1]} : {sr[64:57], sr[8:1]};
		m0 = fsc_errs(word0, pattern) <= {3'h0, tol};
		m1 = fsc_errs(word1, pattern) <= {3'h0, tol};
	end

	// ==================================================
	// search / lock controller
	fsc_sync_e state, next_state;
	logic [1:0] miss, next_miss;
	logic got, next_got, lost;
	logic nominal, late;
	assign nominal = (line_cnt == `FSC_SYNC_LINE) && (bit_cnt == `FSC_HDR_LAST);
	assign late = (line_cnt == `FSC_SYNC_LINE) && (bit_cnt == `FSC_HDR_LAST + 5'h01);

	always_comb
	begin
		next_state = state;
		next_miss = miss;
		next_got = got;
		realign = 1'b0;
		case (state)
			FSC_SEARCH:
			begin
				if (m0)
				begin
					realign = 1'b1;
					next_state = FSC_LOCK;
					next_miss = 2'h0;
					next_got = 1'b0;
				end
			end
			FSC_LOCK:
			begin
				// gate shut outside the window
				if (nominal && (m0 || m1))
				begin
					next_got = 1'b1;
					next_miss = 2'h0;
				end
				else if (late)
				begin
					next_got = 1'b0;
					if (got || m1)
						next_miss = 2'h0;
					else if (miss >= {1'b1, ctrl.frames3})
						next_state = FSC_SEARCH;
					else
						next_miss = miss + 2'h1;
				end
			end
			default:
				next_state = FSC_SEARCH;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= FSC_SEARCH;
			miss <= 2'h0;
			got <= 1'b0;
			lost <= 1'b0;
		end
		else if (ce)
		begin
			lost <= tick && state == FSC_LOCK && next_state == FSC_SEARCH;
			if (tick)
			begin
				state <= next_state;
				miss <= next_miss;
				got <= next_got;
			end
		end
	end

	// ==================================================
	// scan timing and indicators
	logic [25:0] scan_tmr;
	logic [29:0] idle_tmr;
	logic scan_act;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			scan_tmr <= '0;
			idle_tmr <= '0;
			scan_act <= 1'b0;
			lock_ind <= 1'b0;
			search_ind <= 1'b0;
		end
		else if (ce)
		begin
			if (scan_pulse)
			begin
				scan_tmr <= '0;
				idle_tmr <= '0;
				scan_act <= 1'b1;
				lock_ind <= 1'b0;
				search_ind <= 1'b0;
			end
			else
			begin
				if (idle_tmr < 30'(IDLE_CYC))
					idle_tmr <= idle_tmr + 30'h1;
				else
					search_ind <= 1'b1;
				if (scan_act)
				begin
					scan_tmr <= scan_tmr + 26'h1;
					if (scan_tmr == 26'(SCAN_CYC))
						scan_act <= 1'b0; // held through the scan
					if (scan_tmr == 26'(LOCK_WIN_CYC) && state == FSC_LOCK)
						lock_ind <= 1'b1;
					if (lost && scan_tmr >= 26'(LOCK_WIN_CYC))
					begin
						lock_ind <= 1'b0;
						search_ind <= 1'b1;
					end
				end
			end
		end
	end

	// ==================================================
	// infrared capture with Gray to binary
	logic [7:0] gbin;
	assign gbin[7] = sr[7];
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++)
		begin : g_gray
			assign gbin[gi] = sr[gi] ^ gbin[gi + 1];
		end
	endgenerate

	logic hdr;
	assign hdr = tick && bit_cnt == `FSC_HDR_LAST;
	// one load per frame per channel: once per four lines
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ir_out <= '0;
			ir_strobe <= 2'h0;
		end
		else if (ce)
		begin
			ir_strobe[0] <= hdr && line_cnt == `FSC_IRA_LINE;
			ir_strobe[1] <= hdr && line_cnt == `FSC_IRB_LINE;
			if (hdr && line_cnt == `FSC_IRA_LINE)
				ir_out[0] <= '{prev: ir_out[0].cur, cur: gbin};
			if (hdr && line_cnt == `FSC_IRB_LINE)
				ir_out[1] <= '{prev: ir_out[1].cur, cur: gbin};
		end
	end

	// ==================================================
	// visual channels; slow rate carries only the first four
	genvar vi;
	generate
		for (vi = 0; vi < 8; vi++)
		begin : g_vis
			fsc_vis_s ch;
			logic hit, hit_d, stb;
			logic [8:0] lc, lp;
			assign hit = tick && (!ctrl.rate14 || vi < 4) &&
				bit_cnt == 5'(`FSC_VIS_FIRST + `FSC_VIS_STEP * vi);
			fsc_lin_rom u_rc (.code(ch.cur), .lin(lc));
			fsc_lin_rom u_rp (.code(ch.prev), .lin(lp));
			// word pair, then the linear codes a clock later
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					ch <= '0;
					hit_d <= 1'b0;
					stb <= 1'b0;
				end
				else if (ce)
				begin
					hit_d <= hit;
					stb <= hit_d; // strobe when linear codes are valid
					if (hit)
					begin
						ch.prev <= ch.cur;
						ch.cur <= sr[5:0];
					end
					ch.lin_cur <= lc;
					ch.lin_prev <= lp;
				end
			end
			assign vis_out[vi] = ch;
			assign vis_strobe[vi] = stb;
		end
	endgenerate

	// ==================================================
	// AXI4-Lite write path
	logic aw_got, w_got;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `FSC_RESP_OKAY;
			wa <= 8'h00;
			wd <= '0;
			ws <= 4'h0;
			ctrl <= `FSC_CTRL_RST;
			pattern <= `FSC_PAT_RST;
		end
		else if (ce)
		begin
			awready <= !aw_got && !(awvalid && awready) && !bvalid;
			wready <= !w_got && !(wvalid && wready) && !bvalid;
			if (awvalid && awready)
			begin
				aw_got <= 1'b1;
				wa <= {awaddr[7:2], 2'b00};
			end
			if (wvalid && wready)
			begin
				w_got <= 1'b1;
				wd <= wdata;
				ws <= wstrb;
			end
			if (aw_got && w_got && !bvalid)
			begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				bvalid <= 1'b1;
				bresp <= `FSC_RESP_OKAY;
				if (wa == `FSC_ADDR_CTRL && ws[0])
					ctrl <= wd[3:0];
				else if (wa == `FSC_ADDR_PAT)
				begin
					if (ws[0])
						pattern[7:0] <= wd[7:0];
					if (ws[1])
						pattern[15:8] <= wd[15:8];
				end
				else if (wa != `FSC_ADDR_CTRL)
					bresp <= `FSC_RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// ==================================================
	// AXI4-Lite read path
	logic [31:0] rd;
	logic rd_ok;
	logic [7:0] ra;
	assign ra = {araddr[7:2], 2'b00};
	always_comb
	begin
		rd = '0;
		rd_ok = 1'b1;
		// only eight visual words; higher offsets fall to the error path
		if (ra >= `FSC_ADDR_VIS && ra < `FSC_ADDR_VIS + 8'h20)
			rd = {5'h00, vis_out[ra[4:2]].lin_cur, 3'h0, vis_out[ra[4:2]].prev,
				2'h0, vis_out[ra[4:2]].cur, 1'b0};
		else
		case (ra)
			`FSC_ADDR_CTRL: rd = {28'h0, ctrl};
			`FSC_ADDR_PAT: rd = {16'h0, pattern};
			`FSC_ADDR_STAT: rd = {27'h0, miss, search_ind, lock_ind, state};
			`FSC_ADDR_IRA: rd = {16'h0, ir_out[0]};
			`FSC_ADDR_IRB: rd = {16'h0, ir_out[1]};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `FSC_RESP_OKAY;
		end
		else if (ce)
		begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready)
			begin
				rvalid <= 1'b1;
				rdata <= rd;
				rresp <= rd_ok ? `FSC_RESP_OKAY : `FSC_RESP_SLVERR;
			end
			else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end
endmodule

// [dv/fsc_checker.sv]
/*
 Port-level assertions for fsc_core.
 Assumes it is bound into fsc_core with the core's parameters passed on.
*/
`timescale 1ns/1ps
module fsc_checker
	import fsc_pkg::*;
#(
	parameter int SCAN_CYC = 1,
	parameter int IDLE_CYC = 1
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	// indicators and channels
	input wire logic lock_ind,
	input wire logic search_ind,
	input wire logic [1:0] ir_strobe,
	input wire fsc_ir_s [1:0] ir_out,
	input wire logic [7:0] vis_strobe,
	input wire fsc_vis_s [7:0] vis_out
);
	// ==================================================
	// linear lookup, interval base plus scaled position
	localparam logic [8:0] BASE [8] = '{9'h000, 9'h008, 9'h010, 9'h020,
		9'h030, 9'h050, 9'h090, 9'h110};
	localparam int SH [8] = '{0, 0, 1, 1, 2, 3, 4, 5};
	function automatic logic [8:0] lin(input logic [5:0] c);
		return BASE[c[5:3]] + ({6'h00, c[2:0]} << SH[c[5:3]]);
	endfunction
	// ==================================================
	// assertions, one clock domain
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid)
		else $error("read data dropped early");
	AST_B_LAT: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	AST_R_LAT: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	AST_IR_PULSE: assert property (ir_strobe[0] |=> !ir_strobe[0])
		else $error("infrared strobe longer than one cycle");
	AST_IR_SHIFT: assert property (ir_strobe[0] |-> ir_out[0].prev == $past(ir_out[0].cur, 2))
		else $error("infrared previous word not shifted");
	AST_VIS_LIN: assert property (vis_strobe[0] |-> vis_out[0].lin_cur == lin(vis_out[0].cur))
		else $error("visual linear code wrong");
	AST_IND_RST: assert property ($rose(aresetn) |-> !lock_ind && !search_ind)
		else $error("indicator set out of reset");
	// main scenarios
	C_IR: cover property (ir_strobe[0]);
	C_LOCK: cover property ($rose(lock_ind));
	C_WR: cover property (bvalid && bready);
endmodule

// [dv/fsc_demod_model.sv]
/*
 Demodulator stand-in: plays queued bits as x/y pairs on a 200 ns link clock.
 Assumes the bench fills q with whole pairs before calling play.
*/
`timescale 1ns/1ps
module fsc_demod_model (
	// link pins
	output logic link_clk,
	output logic link_x,
	output logic link_y
);
	logic q [$];
	initial
	begin
		link_clk = 1'b0;
		link_x = 1'b0;
		link_y = 1'b0;
	end
	// x is the older bit; data settles half a period before the rise
	task automatic play();
		#7; // step off the aclk edge so no pin change races the sampler
		while (q.size() > 1)
		begin
			link_x = q.pop_front();
			link_y = q.pop_front();
			#100 link_clk = 1'b1;
			#100 link_clk = 1'b0;
		end
		// clock stands still; lines show the inverse so stale bits cannot pass
		link_x = ~link_x;
		link_y = ~link_y;
	endtask
endmodule

// [dv/tb.sv]
/*
 Bench for fsc_core: bus master tasks and frame scenarios.
 Assumes fsc_demod_model drives the link pins.
*/
`timescale 1ns/1ps
`include "fsc_consts.svh"
module tb
	import fsc_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic scan_identifier = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, lock_ind, search_ind;
	logic link_clk, link_x, link_y;
	logic [1:0] bresp, rresp, ir_strobe;
	logic [31:0] rdata;
	logic [7:0] vis_strobe;
	fsc_ir_s [1:0] ir_out;
	fsc_vis_s [7:0] vis_out;
	int n_errors = 0;
	int checked = 0;
	localparam logic [15:0] PAT = 16'h1D4E;
	always #12.5 aclk = ~aclk;
	fsc_demod_model dm (.link_clk(link_clk), .link_x(link_x), .link_y(link_y));
	fsc_core #(.SCAN_CYC(40000), .IDLE_CYC(60000)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.ce(1'b1), .link_clk(link_clk), .link_x(link_x), .link_y(link_y),
		.scan_identifier(scan_identifier), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .lock_ind(lock_ind), .search_ind(search_ind),
		.ir_strobe(ir_strobe), .ir_out(ir_out), .vis_strobe(vis_strobe), .vis_out(vis_out));
	// ==================================================
	// helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// write one word; each channel drops on its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (awvalid && !awready || wvalid && !wready);
		while (!bvalid)
			@(posedge aclk);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (!arready);
		arvalid <= 1'b0;
		while (!rvalid)
			@(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// one frame: sync hi, sync lo, infrared a, infrared b (Gray), nw visual words w a line
	task automatic frame(input logic [15:0] s, input logic [7:0] a, b, input logic [5:0] w,
		input int nw = 8);
		logic [7:0] h [4];
		h = '{s[15:8], s[7:0], a ^ (a >> 1), b ^ (b >> 1)};
		for (int l = 0; l < 4; l++)
		begin
			for (int i = 7; i >= 0; i--)
				dm.q.push_back(h[l][i]);
			for (int k = 0; k < 6 * nw; k++)
				dm.q.push_back(w[5 - k % 6]);
		end
	endtask
	task automatic status_is(input logic e, input string m);
		logic [31:0] d;
		logic [1:0] r;
		repeat (8) @(posedge aclk);
		rd(`FSC_ADDR_STAT, d, r);
		chk(d[0], e, m);
	endtask
	// ==================================================
	// scenarios
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rd(`FSC_ADDR_CTRL, d, r);
		chk(d, 32'h2, "ctrl reset value");
		rd(`FSC_ADDR_PAT, d, r);
		chk(d, 32'hEB90, "pattern reset value");
		rd(8'h40, d, r);
		chk({d[29:0], r}, 32'h2, "unmapped read");
		wr(`FSC_ADDR_STAT, 32'h1, r);
		chk(r, 32'h2, "status write accepted");
		$display("test regs done");
	endtask
	task automatic t_lock();
		logic [1:0] r;
		wr(`FSC_ADDR_PAT, 32'h1D4E, r);
		scan_identifier <= 1'b1;
		frame(PAT, 8'h11, 8'h22, 6'h2B);
		frame(PAT, 8'h5A, 8'h3C, 6'h2B);
		frame(PAT, 8'hC3, 8'hA5, 6'h2B);
		dm.play();
		status_is(1'b1, "no lock on pattern");
		chk(ir_out, 32'h3CA55AC3, "infrared words");
		chk(vis_out[7], {9'h068, 9'h068, 6'h2B, 6'h2B}, "visual words");
		chk(lock_ind, 1'b1, "lock light");
		$display("test lock done");
	endtask
	task automatic t_miss();
		frame(~PAT, 8'h00, 8'h00, 6'h2B);
		frame(~PAT, 8'h00, 8'h00, 6'h2B);
		frame(PAT ^ 16'h0101, 8'h00, 8'h00, 6'h2B);
		frame(~PAT, 8'h00, 8'h00, 6'h2B);
		frame(~PAT, 8'h00, 8'h00, 6'h2B);
		dm.play();
		status_is(1'b1, "lock lost too soon");
		frame(~PAT, 8'h00, 8'h00, 6'h2B);
		dm.play();
		status_is(1'b0, "lock kept too long");
		chk(search_ind, 1'b1, "search light");
		$display("test miss done");
	endtask
	// 14 Mb/s: four words a line, exact match only, three misses allowed
	task automatic t_slow();
		logic [1:0] r;
		wr(`FSC_ADDR_CTRL, 32'hC, r);
		chk(r, 32'h0, "ctrl write refused");
		frame(PAT, 8'h01, 8'h02, 6'h3F, 4);
		frame(PAT, 8'h03, 8'h04, 6'h3F, 4);
		dm.play();
		status_is(1'b1, "no lock at 14 Mb/s");
		chk(ir_out, 32'h02040103, "slow infrared words");
		chk({vis_out[4].cur, vis_out[3].cur}, {6'h2B, 6'h3F}, "slow visual words");
		repeat (3) frame(~PAT, 8'h00, 8'h00, 6'h3F, 4);
		dm.play();
		status_is(1'b1, "third miss dropped lock");
		frame(~PAT, 8'h00, 8'h00, 6'h3F, 4);
		dm.play();
		status_is(1'b0, "fourth miss kept lock");
		$display("test slow done");
	endtask
	// ==================================================
	// run control
	task automatic close_out();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#(25 * 20000);
		n_errors++;
		close_out();
	end
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs();
		t_lock();
		t_miss();
		t_slow();
		close_out();
	end
endmodule
bind fsc_core fsc_checker #(.SCAN_CYC(SCAN_CYC), .IDLE_CYC(IDLE_CYC)) chk_u (.aclk(aclk),
	.aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .lock_ind(lock_ind),
	.search_ind(search_ind), .ir_strobe(ir_strobe), .ir_out(ir_out),
	.vis_strobe(vis_strobe), .vis_out(vis_out));
